// *** hw/gtcm_pkg.sv ***
package gtcm_pkg;
    // ========================================
    // Register byte offsets
    localparam logic [7:0] GTCM_OFF_CTRL = 8'h00;
    localparam logic [7:0] GTCM_OFF_TC = 8'h04;
    localparam logic [7:0] GTCM_OFF_PR = 8'h08;
    localparam logic [7:0] GTCM_OFF_PC = 8'h0C;
    localparam logic [7:0] GTCM_OFF_MCR = 8'h10;
    localparam logic [7:0] GTCM_OFF_CCR = 8'h14;
    localparam logic [7:0] GTCM_OFF_CLR = 8'h18;
    localparam logic [7:0] GTCM_OFF_EMR = 8'h1C;
    localparam logic [7:0] GTCM_OFF_PWM = 8'h20;
    localparam logic [7:0] GTCM_OFF_DMA = 8'h24;
    localparam logic [7:0] GTCM_OFF_IR = 8'h28;
    localparam logic [7:0] GTCM_OFF_IMASK = 8'h2C;
    localparam logic [3:0] GTCM_PAGE_MR = 4'h3;
    localparam logic [3:0] GTCM_PAGE_CR = 4'h4;

    // ========================================
    // Field positions
    localparam int GTCM_CTRL_EN = 0;
    localparam int GTCM_CTRL_SRST = 1;
    localparam int GTCM_CTRL_EXT = 2;
    localparam int GTCM_CTRL_RISE = 3;
    localparam int GTCM_CTRL_FALL = 4;
    localparam int GTCM_MCR_INT = 0;
    localparam int GTCM_MCR_RST = 1;
    localparam int GTCM_MCR_STOP = 2;
    localparam int GTCM_CCR_RISE = 0;
    localparam int GTCM_CCR_FALL = 1;
    localparam int GTCM_CCR_INT = 2;
    localparam int GTCM_STRIDE = 3;
    localparam int GTCM_CLR_EN = 0;
    localparam int GTCM_CLR_SEL = 1;
    localparam int GTCM_CLR_RISE = 3;
    localparam int GTCM_CLR_FALL = 4;
    localparam int GTCM_EMR_ACT = 4;
    localparam logic [3:0] GTCM_PWM_MASK = 4'h7;

    // ========================================
    // Match output actions
    localparam logic [1:0] GTCM_ACT_NONE = 2'h0;
    localparam logic [1:0] GTCM_ACT_LOW = 2'h1;
    localparam logic [1:0] GTCM_ACT_HIGH = 2'h2;
    localparam logic [1:0] GTCM_ACT_TOG = 2'h3;

    // ========================================
    // Carriers and state
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } gtcm_apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } gtcm_apb_rsp_t;

    typedef struct packed {
        logic [4:0] ctrl;
        logic [31:0] pr;
        logic [31:0] pc;
        logic [31:0] tc;
        logic [11:0] mcr;
        logic [11:0] ccr;
        logic [4:0] clr;
        logic [7:0] act;
        logic [3:0] mout;
        logic [3:0] pwmc;
        logic [1:0] dmac;
        logic [7:0] ir;
        logic [7:0] imask;
        logic [3:0][31:0] mr;
        logic [3:0][31:0] cr;
        logic [3:0] cap_prev;
        logic cnt_prev;
        logic [1:0] dma;
        logic [31:0] rdata;
    } gtcm_state_t;

    localparam gtcm_state_t GTCM_STATE_RST = '0;
endpackage

// *** hw/gtcm_top.sv ***
// The address map and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ps
// Functional notes
// - 32-bit counter behind programmable 32-bit prescaler
// - Timer counts clk, counter counts external edges
// - Four capture channels snapshot count, optional IRQ
// - Selected capture event clears timer and prescaler
// - Four match registers, optional IRQ, keep counting
// - Match may stop the timer
// - Match may reset the timer to zero
// - Match outputs low, high, toggle or unchanged
// - Matches 0 and 1 can request DMA
// - PWM on at most three outputs
module gtcm_top (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic ce,
    input wire gtcm_pkg::gtcm_apb_req_t apb_req,
    output gtcm_pkg::gtcm_apb_rsp_t apb_rsp,
    input wire logic [3:0] cap_in,
    input wire logic count_in,
    output logic [3:0] match_out,
    output logic [1:0] dma_req,
    output logic irq
);

    // ========================================
    // State and events
    gtcm_pkg::gtcm_state_t st_r;
    gtcm_pkg::gtcm_state_t st_nxt;

    logic [3:0] mint;
    logic [3:0] mrst;
    logic [3:0] mstop;
    logic [3:0] cint;
    logic [3:0] mev;
    logic [3:0] cev;
    logic ext_edge;
    logic tick;
    logic wrap;
    logic srst;
    logic capclr;
    logic clr_re;
    logic clr_fe;
    logic [1:0] clr_sel;
    logic any_rst;
    logic any_stop;
    logic setup;
    logic acc_wr;
    logic acc_rd;
    logic [32:0] dec;

    assign srst = st_r.ctrl[gtcm_pkg::GTCM_CTRL_SRST];
    assign ext_edge = (st_r.ctrl[gtcm_pkg::GTCM_CTRL_RISE]
                       && count_in && !st_r.cnt_prev)
                   || (st_r.ctrl[gtcm_pkg::GTCM_CTRL_FALL]
                       && !count_in && st_r.cnt_prev);
    assign tick = st_r.ctrl[gtcm_pkg::GTCM_CTRL_EN] && !srst
               && (st_r.ctrl[gtcm_pkg::GTCM_CTRL_EXT] ? ext_edge
                                                       : 1'b1);
    assign wrap = tick && (st_r.pc == st_r.pr);

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_ch
            localparam int B = gi * gtcm_pkg::GTCM_STRIDE;
            assign mint[gi] = st_r.mcr[B + gtcm_pkg::GTCM_MCR_INT];
            assign mrst[gi] = st_r.mcr[B + gtcm_pkg::GTCM_MCR_RST];
            assign mstop[gi] = st_r.mcr[B + gtcm_pkg::GTCM_MCR_STOP];
            assign cint[gi] = st_r.ccr[B + gtcm_pkg::GTCM_CCR_INT];
            assign mev[gi] = wrap && (st_r.tc == st_r.mr[gi]);
            assign cev[gi] = (st_r.ccr[B + gtcm_pkg::GTCM_CCR_RISE]
                              && cap_in[gi] && !st_r.cap_prev[gi])
                          || (st_r.ccr[B + gtcm_pkg::GTCM_CCR_FALL]
                              && !cap_in[gi] && st_r.cap_prev[gi]);
        end
    endgenerate

    assign clr_sel = st_r.clr[gtcm_pkg::GTCM_CLR_SEL +: 2];
    assign clr_re = cap_in[clr_sel] && !st_r.cap_prev[clr_sel];
    assign clr_fe = !cap_in[clr_sel] && st_r.cap_prev[clr_sel];
    assign capclr = st_r.clr[gtcm_pkg::GTCM_CLR_EN]
                 && ((st_r.clr[gtcm_pkg::GTCM_CLR_RISE] && clr_re)
                  || (st_r.clr[gtcm_pkg::GTCM_CLR_FALL] && clr_fe));
    assign any_rst = |(mev & mrst);
    assign any_stop = |(mev & mstop);

    // ========================================
    // Bus decode
    function automatic logic [32:0] read_reg(input logic [7:0] a);
        logic [32:0] r;
        r = {1'b1, 32'h0000_0000};
        if (a[7:4] == gtcm_pkg::GTCM_PAGE_MR) begin
            r[31:0] = st_r.mr[a[3:2]];
        end else if (a[7:4] == gtcm_pkg::GTCM_PAGE_CR) begin
            r[31:0] = st_r.cr[a[3:2]];
        end else begin
            unique case (a)
                gtcm_pkg::GTCM_OFF_CTRL: r[4:0] = st_r.ctrl;
                gtcm_pkg::GTCM_OFF_TC: r[31:0] = st_r.tc;
                gtcm_pkg::GTCM_OFF_PR: r[31:0] = st_r.pr;
                gtcm_pkg::GTCM_OFF_PC: r[31:0] = st_r.pc;
                gtcm_pkg::GTCM_OFF_MCR: r[11:0] = st_r.mcr;
                gtcm_pkg::GTCM_OFF_CCR: r[11:0] = st_r.ccr;
                gtcm_pkg::GTCM_OFF_CLR: r[4:0] = st_r.clr;
                gtcm_pkg::GTCM_OFF_EMR: r[11:0] = {st_r.act, st_r.mout};
                gtcm_pkg::GTCM_OFF_PWM: r[3:0] = st_r.pwmc;
                gtcm_pkg::GTCM_OFF_DMA: r[1:0] = st_r.dmac;
                gtcm_pkg::GTCM_OFF_IR: r[7:0] = st_r.ir;
                gtcm_pkg::GTCM_OFF_IMASK: r[7:0] = st_r.imask;
                default: r[32] = 1'b0;
            endcase
        end
        if (a[1:0] != 2'h0) begin
            r = 33'h0_0000_0000;
        end
        return r;
    endfunction

    assign dec = read_reg(apb_req.paddr);
    assign setup = ce && apb_req.psel && !apb_req.penable;
    assign acc_wr = ce && apb_req.psel && apb_req.penable
                 && apb_req.pwrite && dec[32];
    assign acc_rd = ce && apb_req.psel && apb_req.penable
                 && !apb_req.pwrite;

    // ========================================
    // Next state
    always_comb begin
        st_nxt = st_r;
        if (setup) begin
            st_nxt.rdata = dec[31:0];
        end
        if (acc_wr) begin
            if (apb_req.paddr[7:4] == gtcm_pkg::GTCM_PAGE_MR) begin
                st_nxt.mr[apb_req.paddr[3:2]] = apb_req.pwdata;
            end else begin
                unique case (apb_req.paddr)
                    gtcm_pkg::GTCM_OFF_CTRL: begin
                        st_nxt.ctrl = apb_req.pwdata[4:0];
                    end
                    gtcm_pkg::GTCM_OFF_PR: st_nxt.pr = apb_req.pwdata;
                    gtcm_pkg::GTCM_OFF_MCR: begin
                        st_nxt.mcr = apb_req.pwdata[11:0];
                    end
                    gtcm_pkg::GTCM_OFF_CCR: begin
                        st_nxt.ccr = apb_req.pwdata[11:0];
                    end
                    gtcm_pkg::GTCM_OFF_CLR: begin
                        st_nxt.clr = apb_req.pwdata[4:0];
                    end
                    gtcm_pkg::GTCM_OFF_EMR: begin
                        st_nxt.mout = apb_req.pwdata[3:0];
                        st_nxt.act = apb_req.pwdata[11:4];
                    end
                    gtcm_pkg::GTCM_OFF_PWM: begin
                        st_nxt.pwmc = apb_req.pwdata[3:0]
                                    & gtcm_pkg::GTCM_PWM_MASK;
                    end
                    gtcm_pkg::GTCM_OFF_DMA: begin
                        st_nxt.dmac = apb_req.pwdata[1:0];
                    end
                    gtcm_pkg::GTCM_OFF_IMASK: begin
                        st_nxt.imask = apb_req.pwdata[7:0];
                    end
                    default: begin
                    end
                endcase
            end
        end
        // Prescaler and counter, clears take priority
        if (srst || capclr) begin
            st_nxt.pc = 32'h0000_0000;
            st_nxt.tc = 32'h0000_0000;
        end else if (wrap) begin
            st_nxt.pc = 32'h0000_0000;
            if (any_rst) begin
                st_nxt.tc = 32'h0000_0000;
            end else begin
                st_nxt.tc = st_r.tc + 32'h0000_0001;
            end
        end else if (tick) begin
            st_nxt.pc = st_r.pc + 32'h0000_0001;
        end
        if (any_stop) begin
            st_nxt.ctrl[gtcm_pkg::GTCM_CTRL_EN] = 1'b0;
        end
        for (int i = 0; i < 4; i++) begin
            if (cev[i]) begin
                st_nxt.cr[i] = st_r.tc;
            end
            if (st_r.pwmc[i]) begin
                if (mev[i]) begin
                    st_nxt.mout[i] = 1'b1;
                end else if (any_rst) begin
                    st_nxt.mout[i] = 1'b0;
                end
            end else if (mev[i]) begin
                unique case (st_r.act[2 * i +: 2])
                    gtcm_pkg::GTCM_ACT_LOW: st_nxt.mout[i] = 1'b0;
                    gtcm_pkg::GTCM_ACT_HIGH: st_nxt.mout[i] = 1'b1;
                    gtcm_pkg::GTCM_ACT_TOG: begin
                        st_nxt.mout[i] = !st_r.mout[i];
                    end
                    gtcm_pkg::GTCM_ACT_NONE: begin
                    end
                endcase
            end
        end
        // Only bits seen by the read are cleared; new events win
        if (acc_rd && apb_req.paddr == gtcm_pkg::GTCM_OFF_IR) begin
            st_nxt.ir = st_r.ir & ~st_r.rdata[7:0];
        end
        st_nxt.ir = st_nxt.ir | {cev & cint, mev & mint};
        st_nxt.dma = mev[1:0] & st_r.dmac;
        st_nxt.cap_prev = cap_in;
        st_nxt.cnt_prev = count_in;
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            st_r <= gtcm_pkg::GTCM_STATE_RST;
        end else if (ce) begin
            st_r <= st_nxt;
        end
    end

    // ========================================
    // Outputs
    assign apb_rsp.prdata = st_r.rdata;
    assign apb_rsp.pready = ce;
    assign apb_rsp.pslverr = apb_req.psel && apb_req.penable && !dec[32];
    assign match_out = st_r.mout;
    assign dma_req = st_r.dma;
    assign irq = |(st_r.ir & st_r.imask);

    // ========================================
    // Assertions
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (sys_rst);

    sequence s_plain_tick;
        ce && tick && !wrap && !capclr;
    endsequence

    sequence s_plain_wrap;
        ce && wrap && !capclr && !any_rst;
    endsequence

    property p_tc_inc;
        s_plain_wrap |=> st_r.tc == $past(st_r.tc) + 32'h0000_0001;
    endproperty
    a_tc_inc: assert property (p_tc_inc)
        else $error("timer did not advance on prescaler wrap");

    property p_ext_hold;
        ce && st_r.ctrl[gtcm_pkg::GTCM_CTRL_EXT] && !ext_edge && !capclr
            |=> $stable(st_r.pc) && $stable(st_r.tc);
    endproperty
    a_ext_hold: assert property (p_ext_hold)
        else $error("counter moved without external edge");

    property p_capture;
        ce && cev[0] |=> st_r.cr[0] == $past(st_r.tc);
    endproperty
    a_capture: assert property (p_capture)
        else $error("capture 0 did not take timer value");

    property p_capclr;
        ce && capclr |=> st_r.tc == 32'h0000_0000
            && st_r.pc == 32'h0000_0000;
    endproperty
    a_capclr: assert property (p_capclr)
        else $error("capture clear did not zero counters");

    property p_match_irq;
        ce && mev[2] && mint[2] |=> st_r.ir[2] ##0 (irq == st_r.imask[2])
            or (st_r.ir[2] && irq);
    endproperty
    a_match_irq: assert property (p_match_irq)
        else $error("match flag not set");

    property p_stop;
        ce && any_stop |=> !st_r.ctrl[gtcm_pkg::GTCM_CTRL_EN]
            ##1 ce [*2] |-> $stable(st_r.tc);
    endproperty
    a_stop: assert property (p_stop)
        else $error("timer kept running after stop match");

    property p_reset;
        ce && wrap && any_rst && !capclr |=> st_r.tc == 32'h0000_0000;
    endproperty
    a_reset: assert property (p_reset)
        else $error("reset match did not zero timer");

    property p_toggle;
        ce && mev[0] && !st_r.pwmc[0]
            && st_r.act[1:0] == gtcm_pkg::GTCM_ACT_TOG
            |=> match_out[0] != $past(match_out[0]);
    endproperty
    a_toggle: assert property (p_toggle)
        else $error("match output 0 did not toggle");

    property p_dma;
        ce && mev[1] && st_r.dmac[1] |=> dma_req[1];
    endproperty
    a_dma: assert property (p_dma)
        else $error("DMA request 1 missing");

    property p_pwm_limit;
        st_r.pwmc[3] == 1'b0;
    endproperty
    a_pwm_limit: assert property (p_pwm_limit)
        else $error("PWM enabled on channel 3");

    property p_pwm_level;
        ce && st_r.pwmc[1] && any_rst && !mev[1] |=> !match_out[1];
    endproperty
    a_pwm_level: assert property (p_pwm_level)
        else $error("PWM output not low at cycle start");

    property p_presc;
        s_plain_tick |=> st_r.pc == $past(st_r.pc) + 32'h0000_0001;
    endproperty
    a_presc: assert property (p_presc)
        else $error("prescaler did not count");

endmodule

// *** tb/gtcm_pins.sv ***
`timescale 1ns/1ps
// ========================================
// Capture and count sources
module gtcm_pins (
    output logic [3:0] cap_in,
    output logic count_in,
    input wire logic clk_sys
);
    initial begin
        cap_in = 4'h0;
        count_in = 1'h0;
    end

    // High for w cycles
    task automatic pulse(input int ch, input int w);
        @(posedge clk_sys);
        cap_in[ch] <= 1'h1;
        repeat (w) @(posedge clk_sys);
        cap_in[ch] <= 1'h0;
    endtask

    task automatic clocks(input int n);
        repeat (n) begin
            @(posedge clk_sys);
            count_in <= 1'h1;
            @(posedge clk_sys);
            count_in <= 1'h0;
        end
    endtask
endmodule

// *** tb/gtcm_top_tb.sv ***
`timescale 1ns/1ps
`define CHK(n, e, g) begin \
    cmp_count++; \
    if ((g) !== (e)) begin \
        num_errors++; \
        $display("wrong value %s exp %0h got %0h", n, e, g); \
    end \
end
module gtcm_top_tb;
    typedef struct packed {
        logic [7:0] a;
        logic [31:0] w;
        logic [31:0] e;
        logic err;
    } gtcm_row_t;
    logic clk_sys;
    logic sys_rst;
    logic ce;
    gtcm_pkg::gtcm_apb_req_t req;
    gtcm_pkg::gtcm_apb_rsp_t rsp;
    logic [3:0] cap_in;
    logic count_in;
    logic [3:0] match_out;
    logic [1:0] dma_req;
    logic irq;
    logic [5:0] mon;
    logic [31:0] v;
    logic [31:0] v2;
    logic er;
    int num_errors;
    int cmp_count;
    int n;
    gtcm_row_t rows [17] = '{
        '{8'h00, 32'hFFFF_FFFC, 32'h0000_001C, 1'h0},
        '{8'h04, 32'hFFFF_FFFF, 32'h0000_0000, 1'h0},
        '{8'h08, 32'hA5A5_5A5A, 32'hA5A5_5A5A, 1'h0},
        '{8'h0C, 32'hFFFF_FFFF, 32'h0000_0000, 1'h0},
        '{8'h10, 32'hFFFF_FFFF, 32'h0000_0FFF, 1'h0},
        '{8'h14, 32'hFFFF_FFFF, 32'h0000_0FFF, 1'h0},
        '{8'h18, 32'hFFFF_FFFF, 32'h0000_001F, 1'h0},
        '{8'h1C, 32'hFFFF_FFFF, 32'h0000_0FFF, 1'h0},
        '{8'h20, 32'h0000_000F, 32'h0000_0007, 1'h0},
        '{8'h24, 32'h0000_000F, 32'h0000_0003, 1'h0},
        '{8'h28, 32'h0000_00FF, 32'h0000_0000, 1'h0},
        '{8'h2C, 32'hFFFF_FFFF, 32'h0000_00FF, 1'h0},
        '{8'h30, 32'h1234_5678, 32'h1234_5678, 1'h0},
        '{8'h3C, 32'hFFFF_FFFF, 32'hFFFF_FFFF, 1'h0},
        '{8'h40, 32'hFFFF_FFFF, 32'h0000_0000, 1'h0},
        '{8'h50, 32'hFFFF_FFFF, 32'h0000_0000, 1'h1},
        '{8'h06, 32'hFFFF_FFFF, 32'h0000_0000, 1'h1}
    };

    assign mon = {dma_req, match_out};

    gtcm_top u_gtcm_top (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .ce(ce), .apb_req(req),
        .apb_rsp(rsp), .cap_in(cap_in), .count_in(count_in),
        .match_out(match_out), .dma_req(dma_req), .irq(irq)
    );

    gtcm_pins u_gtcm_pins (
        .cap_in(cap_in), .count_in(count_in), .clk_sys(clk_sys)
    );

    // ========================================
    // Verdict and bus tasks
    task automatic summarize();
        $display("errors %0d compares %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic give_up();
        num_errors++;
        summarize();
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge clk_sys);
        req <= '{psel: 1'h1, penable: 1'h0, pwrite: w, paddr: a, pwdata: d};
        @(posedge clk_sys);
        req.penable <= 1'h1;
        for (k = 0; k < 100; k++) begin
            @(posedge clk_sys);
            if (rsp.pready === 1'h1) break;
        end
        if (k == 100) give_up();
        v = rsp.prdata;
        er = rsp.pslverr;
        req <= '0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'h1, a, d);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        apb(1'h0, a, 32'h0);
        `CHK($sformatf("reg %h", a), e, v)
    endtask

    // Cycles between two rises of a watched pin
    task automatic gap(input int b, output int g);
        logic p;
        int k;
        g = -1;
        p = 1'h1;
        for (k = 0; k < 400; k++) begin
            @(negedge clk_sys);
            if (mon[b] === 1'h1 && p === 1'h0) begin
                if (g >= 0) break;
                g = 0;
            end
            if (g >= 0) g++;
            p = mon[b];
        end
        if (k == 400) give_up();
    endtask

    task automatic restart(input logic [31:0] pr, input logic [31:0] mcr);
        wr(gtcm_pkg::GTCM_OFF_CTRL, 32'h2);
        wr(gtcm_pkg::GTCM_OFF_PR, pr);
        wr(gtcm_pkg::GTCM_OFF_MCR, mcr);
    endtask

    initial begin
        clk_sys = 1'h0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    initial begin
        sys_rst = 1'h1;
        ce = 1'h1;
        req = '0;
        num_errors = 0;
        cmp_count = 0;
        repeat (16) @(posedge clk_sys);
        sys_rst <= 1'h0;
        // ========================================
        // Register table
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].w);
            `CHK("write err", rows[i].err, er)
            rd_chk(rows[i].a, rows[i].e);
            `CHK("read err", rows[i].err, er)
        end
        // ========================================
        // Reset in mid-run
        @(posedge clk_sys);
        sys_rst <= 1'h1;
        @(posedge clk_sys);
        sys_rst <= 1'h0;
        @(negedge clk_sys);
        `CHK("pins", 7'h00, {match_out, dma_req, irq})
        foreach (rows[i]) rd_chk(rows[i].a, 32'h0);
        // ========================================
        // Period, toggle output and DMA spacing
        for (int p = 0; p <= 2; p += 2) begin
            restart(32'(p), 32'h42);
            wr({gtcm_pkg::GTCM_PAGE_MR, 4'h0}, 32'h3);
            wr({gtcm_pkg::GTCM_PAGE_MR, 4'h4}, 32'h1);
            wr({gtcm_pkg::GTCM_PAGE_MR, 4'h8}, 32'h1);
            wr(gtcm_pkg::GTCM_OFF_EMR, 32'h30);
            wr(gtcm_pkg::GTCM_OFF_DMA, 32'h3);
            wr(gtcm_pkg::GTCM_OFF_CTRL, 32'h1);
            gap(0, n);
            `CHK("toggle gap", 8 * (p + 1), n)
            gap(4, n);
            `CHK("dma0 gap", 4 * (p + 1), n)
            gap(5, n);
            `CHK("dma1 gap", 4 * (p + 1), n)
            rd_chk(gtcm_pkg::GTCM_OFF_IR, 32'h4);
        end
        // ========================================
        // Single-edge PWM
        restart(32'h0, 32'h400);
        wr({gtcm_pkg::GTCM_PAGE_MR, 4'hC}, 32'h9);
        wr(gtcm_pkg::GTCM_OFF_EMR, 32'h0);
        wr(gtcm_pkg::GTCM_OFF_DMA, 32'h0);
        wr(gtcm_pkg::GTCM_OFF_PWM, 32'h1);
        wr(gtcm_pkg::GTCM_OFF_CTRL, 32'h1);
        gap(0, n);
        `CHK("pwm period", 10, n)
        n = 0;
        repeat (10) begin
            @(negedge clk_sys);
            n += int'(match_out[0] === 1'h1);
        end
        `CHK("pwm high", 6, n)
        // Clock enable low freezes the running PWM output
        @(posedge clk_sys);
        ce <= 1'h0;
        @(negedge clk_sys);
        v2[0] = match_out[0];
        n = 0;
        repeat (20) begin
            @(negedge clk_sys);
            n += int'(match_out[0] !== v2[0]);
        end
        `CHK("ce freeze", 0, n)
        @(posedge clk_sys);
        ce <= 1'h1;
        wr(gtcm_pkg::GTCM_OFF_PWM, 32'h0);
        // ========================================
        // External count, rising then falling edges
        for (int m = 0; m < 2; m++) begin
            restart(32'h0, 32'h0);
            wr(gtcm_pkg::GTCM_OFF_CTRL, m ? 32'h15 : 32'h0D);
            u_gtcm_pins.clocks(5 - 2 * m);
            rd_chk(gtcm_pkg::GTCM_OFF_TC, 32'(5 - 2 * m));
        end
        // ========================================
        // Pulse width, masked then unmasked interrupt
        restart(32'h0, 32'h0);
        wr(gtcm_pkg::GTCM_OFF_IMASK, 32'h0);
        wr(gtcm_pkg::GTCM_OFF_CCR, 32'h6);
        wr(gtcm_pkg::GTCM_OFF_CLR, 32'h9);
        wr(gtcm_pkg::GTCM_OFF_CTRL, 32'h1);
        u_gtcm_pins.pulse(0, 7);
        rd_chk({gtcm_pkg::GTCM_PAGE_CR, 4'h0}, 32'h6);
        @(negedge clk_sys);
        `CHK("irq masked", 1'h0, irq)
        wr(gtcm_pkg::GTCM_OFF_IMASK, 32'h10);
        repeat (2) @(negedge clk_sys);
        `CHK("irq", 1'h1, irq)
        rd_chk(gtcm_pkg::GTCM_OFF_IR, 32'h10);
        repeat (2) @(negedge clk_sys);
        `CHK("irq cleared", 1'h0, irq)
        rd_chk(gtcm_pkg::GTCM_OFF_IR, 32'h0);
        // ========================================
        // Stop on match
        restart(32'h0, 32'h28);
        wr(gtcm_pkg::GTCM_OFF_CCR, 32'h0);
        wr(gtcm_pkg::GTCM_OFF_CLR, 32'h0);
        wr(gtcm_pkg::GTCM_OFF_IMASK, 32'h2);
        wr({gtcm_pkg::GTCM_PAGE_MR, 4'h4}, 32'h5);
        wr(gtcm_pkg::GTCM_OFF_CTRL, 32'h1);
        for (n = 0; n < 100 && irq !== 1'h1; n++) @(negedge clk_sys);
        if (n == 100) give_up();
        rd_chk(gtcm_pkg::GTCM_OFF_CTRL, 32'h0);
        apb(1'h0, gtcm_pkg::GTCM_OFF_TC, 32'h0);
        v2 = v;
        rd_chk(gtcm_pkg::GTCM_OFF_TC, v2);
        rd_chk(gtcm_pkg::GTCM_OFF_IR, 32'h2);
        summarize();
    end
endmodule
